// ==== core/dbgprt_top.sv ====
// Debug port: test access controller, reset combining, debug interrupt
module dbgprt_top (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       tck,
    input  wire logic       tms,
    input  wire logic       tdi,
    input  wire logic       trstN,
    input  wire logic       chipResetN,
    input  wire logic       emulatorModeSelectN,
    input  wire logic       sleepMode,
    input  wire logic       swStandby,
    input  wire logic       moduleStandby,
    input  wire logic       irqAck,
    output logic            tdo,
    output logic            tdoOe,
    output logic            powerOnReset,
    output logic            debugUnitReset,
    output logic            resetHold,
    output logic            cpuRun,
    output logic            irqReq,
    output logic [3:0]      irqLevel
);
    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    logic [5:0] pinSync;
    dbgprt_sync #(.WIDTH(6)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn ({tck, tms, tdi, trstN, chipResetN, emulatorModeSelectN}),
        .syncOut (pinSync)
    );
    logic tckS, tmsS, tdiS, trstNS, chipRstNS, emuSelNS;
    assign {tckS, tmsS, tdiS, trstNS, chipRstNS, emuSelNS} = pinSync;

    logic tckPrev_ff;
    logic tckRise, tckFall;
    logic standby;
    logic tapReset;
    // Edge detect works on the second flop only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tckPrev_ff <= 1'b1;
        end else begin
            tckPrev_ff <= tckS;
        end
    end
    assign standby = swStandby | moduleStandby;
    // Standby freezes the controller: no edges are honoured
    assign tckRise = tckS & ~tckPrev_ff & ~standby;
    assign tckFall = ~tckS & tckPrev_ff & ~standby;
    assign tapReset = ~trstNS;

    // ****************************************************************
    // Reset combining and reset hold
    // ****************************************************************
    logic emuMode_ff;
    logic hold_ff;
    logic dbgRstCmd_ff;
    // Mode strap is caught while the chip reset pin is low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            emuMode_ff <= 1'b0;
        end else if (!chipRstNS) begin
            emuMode_ff <= ~emuSelNS;
        end
    end

    // Hold is left only through a power-on reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_ff <= 1'b0;
        end else if (!chipRstNS) begin
            hold_ff <= 1'b0;
        end else if (emuMode_ff && !trstNS) begin
            hold_ff <= 1'b1;
        end
    end
    assign powerOnReset   = ~chipRstNS | dbgRstCmd_ff;
    assign debugUnitReset = tapReset;
    assign resetHold      = hold_ff;
    assign cpuRun         = ~powerOnReset & ~hold_ff;

    // ****************************************************************
    // Test access controller state
    // ****************************************************************
    dbgprt_pkg::dbgprt_tap_t state_ff, nxt_state;
    // Next state follows mode select sampled at the rising edge
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            dbgprt_pkg::TLR:    nxt_state = tmsS ? dbgprt_pkg::TLR    : dbgprt_pkg::RTI;
            dbgprt_pkg::RTI:    nxt_state = tmsS ? dbgprt_pkg::SEL_DR : dbgprt_pkg::RTI;
            dbgprt_pkg::SEL_DR: nxt_state = tmsS ? dbgprt_pkg::SEL_IR : dbgprt_pkg::CAP_DR;
            dbgprt_pkg::CAP_DR: nxt_state = tmsS ? dbgprt_pkg::EX1_DR : dbgprt_pkg::SH_DR;
            dbgprt_pkg::SH_DR:  nxt_state = tmsS ? dbgprt_pkg::EX1_DR : dbgprt_pkg::SH_DR;
            dbgprt_pkg::EX1_DR: nxt_state = tmsS ? dbgprt_pkg::UPD_DR : dbgprt_pkg::PA_DR;
            dbgprt_pkg::PA_DR:  nxt_state = tmsS ? dbgprt_pkg::EX2_DR : dbgprt_pkg::PA_DR;
            dbgprt_pkg::EX2_DR: nxt_state = tmsS ? dbgprt_pkg::UPD_DR : dbgprt_pkg::SH_DR;
            dbgprt_pkg::UPD_DR: nxt_state = tmsS ? dbgprt_pkg::SEL_DR : dbgprt_pkg::RTI;
            dbgprt_pkg::SEL_IR: nxt_state = tmsS ? dbgprt_pkg::TLR    : dbgprt_pkg::CAP_IR;
            dbgprt_pkg::CAP_IR: nxt_state = tmsS ? dbgprt_pkg::EX1_IR : dbgprt_pkg::SH_IR;
            dbgprt_pkg::SH_IR:  nxt_state = tmsS ? dbgprt_pkg::EX1_IR : dbgprt_pkg::SH_IR;
            dbgprt_pkg::EX1_IR: nxt_state = tmsS ? dbgprt_pkg::UPD_IR : dbgprt_pkg::PA_IR;
            dbgprt_pkg::PA_IR:  nxt_state = tmsS ? dbgprt_pkg::EX2_IR : dbgprt_pkg::PA_IR;
            dbgprt_pkg::EX2_IR: nxt_state = tmsS ? dbgprt_pkg::UPD_IR : dbgprt_pkg::SH_IR;
            dbgprt_pkg::UPD_IR: nxt_state = tmsS ? dbgprt_pkg::SEL_DR : dbgprt_pkg::RTI;
            default:            nxt_state = dbgprt_pkg::TLR;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst || tapReset) begin
            state_ff <= dbgprt_pkg::TLR;
        end else if (tckRise) begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************************************
    // Shift paths: sample on rise, shift on fall
    // ****************************************************************
    logic                         tdiSample_ff;
    logic [dbgprt_pkg::IR_LEN-1:0] irShift_ff;
    logic [dbgprt_pkg::IR_LEN-1:0] instr_ff;
    logic                         bypass_ff;
    logic                         inShiftIr, inShiftDr;
    logic                         irPend_ff, drPend_ff;
    assign inShiftIr = (state_ff == dbgprt_pkg::SH_IR);
    assign inShiftDr = (state_ff == dbgprt_pkg::SH_DR);

    // A bit sampled on a rise in a shift state moves in at the next fall,
    // so the last bit, sampled as the controller leaves shift, is not lost
    always_ff @(posedge ref_clk) begin
        if (rst || tapReset) begin
            irPend_ff <= 1'b0;
            drPend_ff <= 1'b0;
        end else if (tckRise) begin
            irPend_ff <= inShiftIr;
            drPend_ff <= inShiftDr;
        end else if (tckFall) begin
            irPend_ff <= 1'b0;
            drPend_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tdiSample_ff <= 1'b0;
        end else if (tckRise) begin
            tdiSample_ff <= tdiS;
        end
    end

    // Capture loads fixed pattern; shifting happens on the falling edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irShift_ff <= dbgprt_pkg::IR_CAPTURE;
        end else if (tckFall && state_ff == dbgprt_pkg::CAP_IR) begin
            irShift_ff <= dbgprt_pkg::IR_CAPTURE;
        end else if (tckFall && irPend_ff) begin
            irShift_ff <= {tdiSample_ff, irShift_ff[dbgprt_pkg::IR_LEN-1:1]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bypass_ff <= 1'b0;
        end else if (tckFall && drPend_ff) begin
            bypass_ff <= tdiSample_ff;
        end
    end

    // Instruction persists until the next Update-IR or test-logic-reset
    always_ff @(posedge ref_clk) begin
        if (rst || tapReset || state_ff == dbgprt_pkg::TLR) begin
            instr_ff <= dbgprt_pkg::IR_RESET_VAL;
        end else if (tckFall && state_ff == dbgprt_pkg::UPD_IR) begin
            instr_ff <= irShift_ff;
        end
    end

    logic [3:0] cmdNib;
    logic [7:0] cmdByte;
    logic       updPulse_ff;
    assign cmdNib  = instr_ff[dbgprt_pkg::CMD_HI:dbgprt_pkg::CMD_NIB_LO];
    assign cmdByte = instr_ff[dbgprt_pkg::CMD_HI:dbgprt_pkg::CMD_BYTE_LO];

    // One-cycle marker that a fresh instruction was just loaded
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            updPulse_ff <= 1'b0;
        end else begin
            // Reloading the standing command changes nothing
            updPulse_ff <= tckFall && state_ff == dbgprt_pkg::UPD_IR && !tapReset
                           && irShift_ff != instr_ff;
        end
    end

    // ****************************************************************
    // Output edge selection and data output
    // ****************************************************************
    logic riseEdge_ff;
    logic tdo_ff;
    logic tdoOe_ff;
    logic shiftBit;
    // Cleared only when test reset coincides with power-on reset
    always_ff @(posedge ref_clk) begin
        if (rst || (tapReset && !chipRstNS)) begin
            riseEdge_ff <= 1'b0;
        end else if (updPulse_ff && cmdByte == dbgprt_pkg::CMD_EDGE_SW) begin
            riseEdge_ff <= 1'b1;
        end
    end

    // A fall that also shifts shows the bit that the shift brings forward
    assign shiftBit = inShiftIr ? (irPend_ff ? irShift_ff[1] : irShift_ff[0])
                    : (cmdNib == dbgprt_pkg::CMD_BYPASS)
                    ? (drPend_ff ? tdiSample_ff : bypass_ff) : 1'b0;

    // Output is launched on whichever edge is selected
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tdo_ff   <= 1'b0;
            tdoOe_ff <= 1'b0;
        end else if (riseEdge_ff ? tckRise : tckFall) begin
            tdo_ff   <= shiftBit;
            tdoOe_ff <= inShiftIr | inShiftDr;
        end else if (!(inShiftIr || inShiftDr)) begin
            tdoOe_ff <= 1'b0;
        end
    end
    assign tdo   = tdo_ff;
    assign tdoOe = tdoOe_ff;

    // ****************************************************************
    // Debug reset command and debug interrupt
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dbgRstCmd_ff <= 1'b0;
        end else if (updPulse_ff && cmdNib == dbgprt_pkg::CMD_RST_ASSERT) begin
            dbgRstCmd_ff <= 1'b1;
        end else if (updPulse_ff && cmdNib == dbgprt_pkg::CMD_RST_NEG) begin
            dbgRstCmd_ff <= 1'b0;
        end
    end

    logic irqPend_ff;
    // A new interrupt command raises the request; acknowledge set loses to a new load
    always_ff @(posedge ref_clk) begin
        if (rst || powerOnReset) begin
            irqPend_ff <= 1'b0;
        end else if (updPulse_ff && cmdNib == dbgprt_pkg::CMD_IRQ) begin
            irqPend_ff <= 1'b1;
        end else if (irqAck) begin
            irqPend_ff <= 1'b0;
        end
    end
    // Masked in software standby, passes in sleep
    assign irqReq   = irqPend_ff & ~swStandby;
    assign irqLevel = dbgprt_pkg::IRQ_LEVEL;
endmodule

// ==== core/dbgprt_pkg.sv ====
// Package of constants for the debug port reset and interrupt control block
package dbgprt_pkg;
    localparam int          IR_LEN        = 16;
    localparam logic [15:0] IR_RESET_VAL  = 16'hcffd;
    localparam logic [15:0] IR_CAPTURE    = 16'h00fd;
    localparam logic [3:0]  CMD_RST_NEG   = 4'h6;
    localparam logic [3:0]  CMD_RST_ASSERT = 4'h7;
    localparam logic [7:0]  CMD_EDGE_SW   = 8'h9c;
    localparam logic [3:0]  CMD_IRQ       = 4'hb;
    localparam logic [3:0]  CMD_BYPASS    = 4'hf;
    localparam logic [3:0]  IRQ_LEVEL     = 4'hf;
    localparam int          CMD_HI        = 15;
    localparam int          CMD_NIB_LO    = 12;
    localparam int          CMD_BYTE_LO   = 8;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } dbgprt_tap_t;
endpackage

// ==== core/dbgprt_sync.sv ====
// Two-flop synchroniser bank for pins entering the ref_clk domain
module dbgprt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // One generate instance per bit keeps each path independent
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                meta_ff[i] <= 1'b0;
                sync_ff[i] <= 1'b0;
            end else begin
                meta_ff[i] <= asyncIn[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end
    assign syncOut = sync_ff;
endmodule

// ==== tb/dbgprt_chk.sv ====
// Checker of the debug port pin relations, bound to the top module
module dbgprt_chk (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       trstN,
    input wire logic       chipResetN,
    input wire logic       emulatorModeSelectN,
    input wire logic       swStandby,
    input wire logic       irqAck,
    input wire logic       tdoOe,
    input wire logic       powerOnReset,
    input wire logic       debugUnitReset,
    input wire logic       resetHold,
    input wire logic       cpuRun,
    input wire logic       irqReq,
    input wire logic [3:0] irqLevel
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Emulator mode, chip reset released, test reset just pulled low
    sequence s_hold_cause;
        !emulatorModeSelectN && chipResetN && $fell(trstN);
    endsequence
    // A pending request that nothing is clearing this cycle
    sequence s_irq_live;
        irqReq && !irqAck && !powerOnReset;
    endsequence
    property p_irq_level; irqLevel == dbgprt_pkg::IRQ_LEVEL; endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
    property p_cpu_run; cpuRun == (!powerOnReset && !resetHold); endproperty
    a_cpu_run: assert property (p_cpu_run) else $error("cpu run wrong");
    property p_por_pin; $fell(chipResetN) |-> ##[1:4] powerOnReset; endproperty
    a_por_pin: assert property (p_por_pin) else $error("no power-on reset");
    property p_dbg_reset; $stable(trstN) [*4] |-> debugUnitReset == !trstN; endproperty
    a_dbg_reset: assert property (p_dbg_reset) else $error("debug reset wrong");
    property p_irq_stby; swStandby |-> !irqReq; endproperty
    a_irq_stby: assert property (p_irq_stby) else $error("irq in standby");
    property p_irq_keep; s_irq_live |=> irqReq || swStandby; endproperty
    a_irq_keep: assert property (p_irq_keep) else $error("irq dropped");
    property p_tdo_float; debugUnitReset [*3] |-> !tdoOe; endproperty
    a_tdo_float: assert property (p_tdo_float) else $error("tdo driven");
    property p_hold_enter; s_hold_cause |-> ##[1:5] resetHold; endproperty
    a_hold_enter: assert property (p_hold_enter) else $error("no reset hold");
    // Only a power-on reset may end the hold; the register lags it by a cycle
    property p_hold_keep; $fell(resetHold) |-> $past(powerOnReset) || powerOnReset; endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("hold left early");
endmodule
bind dbgprt_top dbgprt_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .trstN(trstN), .chipResetN(chipResetN),
    .emulatorModeSelectN(emulatorModeSelectN), .swStandby(swStandby), .irqAck(irqAck),
    .tdoOe(tdoOe), .powerOnReset(powerOnReset), .debugUnitReset(debugUnitReset),
    .resetHold(resetHold), .cpuRun(cpuRun), .irqReq(irqReq), .irqLevel(irqLevel));

// ==== tb/dbgprt_emu.sv ====
// Emulator model that drives the test port pins of the debug block
module dbgprt_emu (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trstN,
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    logic lowSmp;
    logic highSmp;
    // Test clock rests high outside frames so the port state survives standby
    initial begin
        tck = 1'h1;
        tms = 1'h1;
        tdi = 1'h0;
        trstN = 1'h0;
    end
    // Change the test reset off the system clock edge, then idle 250 ns
    task automatic set_trst(input logic v);
        #10;
        trstN = v;
        #250;
    endtask
    // One test clock; pins change on the fall, the device samples on the rise
    task automatic step(input logic m, input logic d);
        #((160 - $time % 100) % 100);
        tck = 1'h0;
        tms = m;
        tdi = d;
        #395 lowSmp = tdo;
        #5 tck = 1'h1;
        #395 highSmp = tdo;
        #5;
    endtask
    // Full scan from idle: IR or DR, 16 bits LSB first, back to idle
    task automatic scan(input logic ir, input logic [15:0] d,
                        output logic [15:0] lo, output logic [15:0] hi);
        step(1'h1, 1'h0);
        if (ir) step(1'h1, 1'h0);
        step(1'h0, 1'h0);
        step(1'h0, 1'h0);
        for (int i = 0; i < 16; i++) begin
            step(i == 15, d[i]);
            lo[i] = lowSmp;
            hi[i] = highSmp;
        end
        step(1'h1, 1'h0);
        step(1'h0, 1'h0);
    endtask
    // Five ones reach test-logic-reset from any state, then go idle
    task automatic tap_reset();
        repeat (5) step(1'h1, 1'h0);
        step(1'h0, 1'h0);
    endtask
endmodule

// ==== tb/dbgprt_top_tb_top.sv ====
// Self-checking bench for the debug port block and its emulator partner
module dbgprt_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Bench
    // ****************************************************************
    logic        ref_clk, rst, tck, tms, tdi, trstN, chipResetN, emulatorModeSelectN;
    logic        sleepMode, swStandby, moduleStandby, irqAck, tdo, tdoOe;
    logic        powerOnReset, debugUnitReset, resetHold, cpuRun, irqReq;
    logic [3:0]  irqLevel;
    logic [15:0] lo, hi, d;
    int          n_fail, checks_done;
    dbgprt_top dut (
        .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
        .chipResetN(chipResetN), .emulatorModeSelectN(emulatorModeSelectN),
        .sleepMode(sleepMode), .swStandby(swStandby), .moduleStandby(moduleStandby),
        .irqAck(irqAck), .tdo(tdo), .tdoOe(tdoOe), .powerOnReset(powerOnReset),
        .debugUnitReset(debugUnitReset), .resetHold(resetHold), .cpuRun(cpuRun),
        .irqReq(irqReq), .irqLevel(irqLevel));
    dbgprt_emu emu (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo));
    // Command word: code in the top nibble, fixed low bits
    function automatic logic [15:0] cmd(input logic [3:0] nib);
        return {nib, 12'h0fd};
    endfunction
    // Bypass delays by one bit; bit 0 is the bypass bit left from the previous scan, masked off
    function automatic logic [15:0] by_exp(input logic [15:0] v);
        return {v[14:0], 1'h0};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Hang guard: a run that outlives its budget counts as a failure
    initial begin
        #5ms;
        n_fail++;
        report_and_stop();
    end
    // Main sequence; chip and test reset changes stay 25 cycles apart, except where both go low together
    initial begin
        {n_fail, checks_done} = '0;
        {rst, chipResetN, emulatorModeSelectN} = 3'h5;
        {sleepMode, swStandby, moduleStandby, irqAck} = 4'h0;
        void'($urandom(40));
        cyc(20);
        rst <= 1'h0;
        cyc(5);
        chk("por", {powerOnReset, debugUnitReset, cpuRun, tdoOe}, 4'hc);
        chipResetN <= 1'h1;
        cyc(25);
        chk("debug only", {powerOnReset, debugUnitReset, cpuRun, tdoOe}, 4'h6);
        emu.set_trst(1'h1);
        cyc(3);
        chk("normal", {powerOnReset, debugUnitReset, cpuRun, irqReq}, 4'h2);
        $display("test power-up done");
        moduleStandby <= 1'h1;
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_IRQ), lo, hi);
        chk("irq standby", irqReq, 1'h0);
        cyc(1);
        moduleStandby <= 1'h0;
        emu.tap_reset();
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_IRQ), lo, hi);
        chk("capture", hi, dbgprt_pkg::IR_CAPTURE);
        chk("irq", {irqReq, irqLevel}, 5'h1f);
        cyc(1);
        sleepMode <= 1'h1;
        cyc(3);
        chk("irq sleep", irqReq, 1'h1);
        swStandby <= 1'h1;
        cyc(3);
        chk("irq sw standby", irqReq, 1'h0);
        {swStandby, sleepMode} <= 2'h0;
        cyc(3);
        chk("irq pending", irqReq, 1'h1);
        irqAck <= 1'h1;
        cyc(1);
        irqAck <= 1'h0;
        cyc(3);
        chk("irq acked", irqReq, 1'h0);
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_IRQ), lo, hi);
        chk("repeat ignored", irqReq, 1'h0);
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_BYPASS), lo, hi);
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_IRQ), lo, hi);
        chk("irq again", irqReq, 1'h1);
        $display("test interrupt done");
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_RST_ASSERT), lo, hi);
        chk("reset cmd", {powerOnReset, cpuRun, irqReq}, 3'h4);
        cyc(30);
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_BYPASS), lo, hi);
        chk("reset held", powerOnReset, 1'h1);
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_RST_NEG), lo, hi);
        chk("reset off", {powerOnReset, cpuRun}, 2'h1);
        $display("test reset command done");
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_BYPASS), lo, hi);
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : 16'($urandom);
            emu.scan(1'h0, d, lo, hi);
            chk("bypass", hi & 16'hfffe, by_exp(d));
            chk("fall edge", lo & 16'hfffe, hi & 16'hfffe);
        end
        $display("test bypass done");
        emu.scan(1'h1, {dbgprt_pkg::CMD_EDGE_SW, 8'hfd}, lo, hi);
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_BYPASS), lo, hi);
        emu.scan(1'h0, 16'h5555, lo, hi);
        chk("rise edge", (lo ^ hi) & 16'h7ffc, 16'h7ffc);
        $display("test edge switch done");
        cyc(1);
        chipResetN <= 1'h0;
        emu.set_trst(1'h0);
        cyc(25);
        chipResetN <= 1'h1;
        cyc(25);
        emu.set_trst(1'h1);
        emu.tap_reset();
        emu.scan(1'h1, cmd(dbgprt_pkg::CMD_BYPASS), lo, hi);
        chk("capture again", hi, dbgprt_pkg::IR_CAPTURE);
        emu.scan(1'h0, 16'h5555, lo, hi);
        chk("fall restored", lo & 16'hfffe, hi & 16'hfffe);
        $display("test edge restore done");
        cyc(1);
        {chipResetN, emulatorModeSelectN} <= 2'h0;
        cyc(25);
        chipResetN <= 1'h1;
        cyc(25);
        emu.set_trst(1'h0);
        cyc(5);
        chk("hold entered", {resetHold, cpuRun}, 2'h2);
        cyc(20);
        emu.set_trst(1'h1);
        cyc(5);
        chk("hold kept", {resetHold, cpuRun}, 2'h2);
        cyc(20);
        chipResetN <= 1'h0;
        cyc(25);
        chipResetN <= 1'h1;
        cyc(25);
        chk("hold left", {resetHold, cpuRun}, 2'h1);
        $display("test reset hold done");
        report_and_stop();
    end
endmodule
